// file: rtl/dcls_sequencer.sv
// Purpose: Drives CTS, DSR, DCD and RI toward a host or terminal and watches DTR.
// Assumes: Call processing supplies incoming, answered, busy and release events as pulses.
// Notes: Modes below 8 are outside this block; leads then stay off.
`include "dcls_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module dcls_sequencer #(
  parameter int MS_CYCLES = `DCLS_MS_CYCLES,
  parameter int RING_ON_MS = `DCLS_RING_ON_MS,
  parameter int RING_OFF_MS = `DCLS_RING_OFF_MS,
  parameter int RELEASE_MS = `DCLS_RELEASE_MS,
  parameter int BUSY_MS = `DCLS_BUSY_MS,
  parameter int RETRY_MS = `DCLS_RETRY_MS,
  parameter int DROP_MS = `DCLS_DROP_MS
) (
  input wire logic sys_clk_i,                 // System clock, 200 MHz.
  input wire logic resetn_i,                  // Asynchronous reset, active low.
  input wire logic [3:0] mode_i,              // Operating mode number.
  input wire logic busy_on_line_drop_option_i, // Make-set-busy on long DTR drop.
  input wire logic [2:0] baud_switch_i,       // Switches 6, 7 and 8.
  input wire logic dtr_i,                     // DTR pin from the DTE.
  input wire logic call_incoming_i,           // Pulse: incoming call offered.
  input wire logic protocol_ok_i,             // Pulse: data module exchange succeeded.
  input wire logic far_answer_i,              // Pulse: called unit answered.
  input wire logic far_busy_i,                // Pulse: called unit busy.
  input wire logic far_free_i,                // Pulse: ring-again unit now free.
  input wire logic call_released_i,           // Pulse: call released by the far end.
  input wire logic break_release_i,           // Pulse: long break or three short breaks.
  input wire logic dial_cmd_i,                // Pulse: dialing command received.
  input wire logic rx_char_valid_i,           // Pulse: command character received.
  input wire logic [7:0] rx_char_i,           // Received character.
  output logic cts_o,                         // Clear to send, high is ON.
  output logic dsr_o,                         // Data set ready, high is ON.
  output logic dcd_o,                         // Carrier detect, high is ON.
  output logic ri_o,                          // Ring indicator, high is ON.
  output logic answer_o,                      // Pulse: answer the incoming call.
  output logic originate_o,                   // Pulse: originate dialed call.
  output logic hotline_o,                     // Pulse: place hotline call.
  output logic ring_again_o,                  // Pulse: invoke ring-again.
  output logic release_o,                     // Pulse: release the call.
  output logic make_set_busy_o,               // Level: unit is made busy.
  output logic [2:0] hotline_baud_o,          // Baud code for hotline calls.
  output logic prompts_en_o,                  // Level: menus and prompts allowed.
  output logic echo_en_o,                     // Level: echo command characters.
  output logic cmd_accept_o,                  // Level: commands and autobaud allowed.
  output logic [2:0] state_o                  // Current sequencer state code.
);

  dcls_pkg::dcls_state_t state;
  dcls_pkg::dcls_state_t next_state;
  logic tick, dtr_f, dtr_prev, dtr_eff, dtr_watched;
  logic host_mode, term_mode, lead_keep_on, ri_mode;
  logic [15:0] ms_cnt, dtr_off_ms, retry_ms;
  logic ring_phase, drop_done, rel_long, idle_ctrl_z;

  // Mode range test used by the mode-group decode.
  function automatic logic in_range(input logic [3:0] m, input logic [3:0] lo, input logic [3:0] hi);
    in_range = (m >= lo) && (m <= hi);
  endfunction

  dcls_tick_gen #(.CYCLES(MS_CYCLES)) u_tick (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .tick_o(tick)
  );

  dcls_dtr_filter #(.TICKS(`DCLS_DEBOUNCE_TICKS)) u_dtr (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .tick_i(tick),
    .dtr_i(dtr_i),
    .dtr_o(dtr_f)
  );

  // Mode groups and the effective DTR level.
  always_comb begin
    host_mode = in_range(mode_i, `DCLS_MODE_HOST_BASE, `DCLS_MODE_LEASED);
    term_mode = in_range(mode_i, `DCLS_MODE_TERM_BASE, `DCLS_MODE_TERM_LEASED);
    dtr_watched = mode_i != `DCLS_MODE_TERM_FORCED;
    dtr_eff = (mode_i == `DCLS_MODE_FORCED || mode_i == `DCLS_MODE_TERM_FORCED) ? 1'b1 : dtr_f;
    lead_keep_on = term_mode;
    ri_mode = host_mode || (term_mode && mode_i != `DCLS_MODE_TERM_FORCED);
    rel_long = dtr_off_ms > 16'(RELEASE_MS);
    idle_ctrl_z = rx_char_valid_i && rx_char_i == `DCLS_CTRL_Z && state == dcls_pkg::ST_IDLE && term_mode;
  end

  // Host modes stay silent; terminal modes prompt and echo.
  always_comb begin
    prompts_en_o = term_mode;
    echo_en_o = term_mode;
    cmd_accept_o = (host_mode || term_mode) && (dtr_eff || !dtr_watched);
    hotline_baud_o = (mode_i == `DCLS_MODE_LEASED) ? baud_switch_i : 3'h0;
    state_o = state;
  end

  // Track the previous filtered DTR level for edge detection.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dtr_prev <= 1'b0;
    end else begin
      dtr_prev <= dtr_f;
    end
  end

  // Measure how long DTR has been off, in milliseconds.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dtr_off_ms <= 16'h0;
    end else if (dtr_f) begin
      dtr_off_ms <= 16'h0;
    end else if (tick && dtr_off_ms != 16'hFFFF) begin
      dtr_off_ms <= dtr_off_ms + 16'h1;
    end
  end

  // Make-set-busy once DTR stays off past the busy time with the option set, except in modes 10 and 14.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      make_set_busy_o <= 1'b0;
    end else begin
      make_set_busy_o <= busy_on_line_drop_option_i && dtr_watched && (host_mode || term_mode)
                         && mode_i != `DCLS_MODE_FORCED && dtr_off_ms > 16'(BUSY_MS);
    end
  end

  // Shared millisecond counter for ringing cadence and the drop pulse.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ms_cnt <= 16'h0;
      ring_phase <= 1'b0;
    end else if (state != next_state) begin
      ms_cnt <= 16'h0;
      ring_phase <= 1'b1;
    end else if (tick) begin
      if (state == dcls_pkg::ST_RINGING && ring_phase && ms_cnt == 16'(RING_ON_MS - 1)) begin
        ms_cnt <= 16'h0;
        ring_phase <= 1'b0;
      end else if (state == dcls_pkg::ST_RINGING && !ring_phase && ms_cnt == 16'(RING_OFF_MS - 1)) begin
        ms_cnt <= 16'h0;
        ring_phase <= 1'b1;
      end else begin
        ms_cnt <= ms_cnt + 16'h1;
      end
    end
  end

  assign drop_done = tick && ms_cnt == 16'(DROP_MS - 1);

  // Hotline retry timer, running whenever the sequencer is in the dialing state.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      retry_ms <= 16'h0;
    end else if (state != dcls_pkg::ST_DIALING) begin
      retry_ms <= 16'h0;
    end else if (tick) begin
      retry_ms <= (retry_ms == 16'(RETRY_MS - 1)) ? 16'h0 : retry_ms + 16'h1;
    end
  end

  // Next-state selection for the call sequence.
  always_comb begin
    logic leased;
    logic can_go;
    leased = mode_i == `DCLS_MODE_LEASED || mode_i == `DCLS_MODE_TERM_LEASED;
    can_go = host_mode || term_mode;
    next_state = state;
    unique case (state)
      dcls_pkg::ST_IDLE: begin
        if (!can_go) begin
          next_state = dcls_pkg::ST_IDLE;
        end else if (call_incoming_i) begin
          next_state = dtr_eff ? dcls_pkg::ST_ANSWER : dcls_pkg::ST_RINGING;
        end else if (leased && dtr_f) begin
          next_state = dcls_pkg::ST_DIALING;
        end else if ((mode_i == `DCLS_MODE_HOTLINE || mode_i == `DCLS_MODE_TERM_HOT) && dtr_f && !dtr_prev) begin
          next_state = dcls_pkg::ST_DIALING;
        end else if (dial_cmd_i && cmd_accept_o) begin
          next_state = dcls_pkg::ST_DIALING;
        end else if (idle_ctrl_z && mode_i == `DCLS_MODE_TERM_BASE) begin
          next_state = dcls_pkg::ST_DROP;
        end
      end
      dcls_pkg::ST_RINGING: begin
        if (call_released_i) begin
          next_state = dcls_pkg::ST_IDLE;
        end else if (dtr_eff) begin
          next_state = dcls_pkg::ST_ANSWER;
        end
      end
      dcls_pkg::ST_ANSWER: begin
        if (call_released_i) begin
          next_state = term_mode ? dcls_pkg::ST_DROP : dcls_pkg::ST_IDLE;
        end else if (protocol_ok_i) begin
          next_state = dcls_pkg::ST_CONNECTED;
        end
      end
      dcls_pkg::ST_DIALING: begin
        if (leased && !dtr_f) begin
          next_state = dcls_pkg::ST_IDLE;
        end else if (far_busy_i && leased) begin
          next_state = dcls_pkg::ST_RING_AGAIN;
        end else if (far_answer_i || (!leased && protocol_ok_i)) begin
          next_state = dcls_pkg::ST_CONNECTED;
        end else if (call_released_i && !leased) begin
          next_state = dcls_pkg::ST_IDLE;
        end
      end
      dcls_pkg::ST_RING_AGAIN: begin
        if (!dtr_f) begin
          next_state = dcls_pkg::ST_IDLE;
        end else if (far_free_i) begin
          next_state = dcls_pkg::ST_CONNECTED;
        end
      end
      dcls_pkg::ST_CONNECTED: begin
        if (call_released_i || break_release_i || (dtr_watched && mode_i != `DCLS_MODE_FORCED && rel_long)) begin
          next_state = term_mode ? dcls_pkg::ST_DROP : dcls_pkg::ST_IDLE;
        end
      end
      dcls_pkg::ST_DROP: begin
        if (drop_done) begin
          next_state = dcls_pkg::ST_IDLE;
        end
      end
      default: next_state = dcls_pkg::ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= dcls_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Call-processing strobes issued on state entry or on retry expiry.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      answer_o <= 1'b0;
      originate_o <= 1'b0;
      hotline_o <= 1'b0;
      ring_again_o <= 1'b0;
      release_o <= 1'b0;
    end else begin
      answer_o <= state != dcls_pkg::ST_ANSWER && next_state == dcls_pkg::ST_ANSWER;
      originate_o <= state == dcls_pkg::ST_IDLE && next_state == dcls_pkg::ST_DIALING && dial_cmd_i;
      hotline_o <= (state == dcls_pkg::ST_IDLE && next_state == dcls_pkg::ST_DIALING && !dial_cmd_i)
                   || (state == dcls_pkg::ST_DIALING && next_state == dcls_pkg::ST_DIALING
                       && tick && retry_ms == 16'(RETRY_MS - 1));
      ring_again_o <= state == dcls_pkg::ST_DIALING && next_state == dcls_pkg::ST_RING_AGAIN;
      release_o <= state == dcls_pkg::ST_CONNECTED && next_state != dcls_pkg::ST_CONNECTED
                   && !call_released_i;
    end
  end

  // Control leads: host modes on only when connected, mode 12 on except in drop.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cts_o <= 1'b0;
      dsr_o <= 1'b0;
      dcd_o <= 1'b0;
      ri_o <= 1'b0;
    end else begin
      if (mode_i == `DCLS_MODE_TERM_BASE) begin
        cts_o <= next_state != dcls_pkg::ST_DROP;
        dsr_o <= next_state != dcls_pkg::ST_DROP;
        dcd_o <= next_state != dcls_pkg::ST_DROP;
      end else begin
        cts_o <= (host_mode || lead_keep_on) && next_state == dcls_pkg::ST_CONNECTED;
        dsr_o <= (host_mode || lead_keep_on) && next_state == dcls_pkg::ST_CONNECTED;
        dcd_o <= (host_mode || lead_keep_on) && next_state == dcls_pkg::ST_CONNECTED;
      end
      ri_o <= ri_mode && next_state == dcls_pkg::ST_RINGING
              && (state != dcls_pkg::ST_RINGING || ring_phase);
    end
  end

endmodule
`default_nettype wire

// file: common/dcls_consts.svh
// Purpose: Constants for the control-lead sequencer: modes, timing and tick rates.
// Assumes: 200 MHz system clock; times are given in their own units and converted.
// Notes: Included by bare name; definitions only.
`ifndef DCLS_CONSTS_SVH
`define DCLS_CONSTS_SVH

`define DCLS_CLK_HZ 200000000
`define DCLS_MS_CYCLES (`DCLS_CLK_HZ / 1000)
`define DCLS_MODE_HOST_BASE 4'h8
`define DCLS_MODE_HOTLINE 4'h9
`define DCLS_MODE_FORCED 4'hA
`define DCLS_MODE_LEASED 4'hB
`define DCLS_MODE_TERM_BASE 4'hC
`define DCLS_MODE_TERM_HOT 4'hD
`define DCLS_MODE_TERM_FORCED 4'hE
`define DCLS_MODE_TERM_LEASED 4'hF
`define DCLS_RING_ON_MS 2000
`define DCLS_RING_OFF_MS 4000
`define DCLS_RELEASE_MS 100
`define DCLS_BUSY_MS 5000
`define DCLS_RETRY_MS 40000
`define DCLS_DROP_MS 200
`define DCLS_DEBOUNCE_TICKS 2
`define DCLS_CTRL_Z 8'h1A

`endif

// file: common/dcls_pkg.sv
// Purpose: Types shared by the control-lead sequencer files.
// Assumes: Constants come from dcls_consts.svh.
// Notes: Nothing in here holds a number other than state codes.
package dcls_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RINGING = 3'b001,
    ST_ANSWER = 3'b010,
    ST_CONNECTED = 3'b011,
    ST_DIALING = 3'b100,
    ST_RING_AGAIN = 3'b101,
    ST_DROP = 3'b110
  } dcls_state_t;

endpackage

// file: rtl/dcls_tick_gen.sv
// Purpose: Produces a one-cycle millisecond enable pulse from the system clock.
// Assumes: CYCLES is the number of system clocks in one millisecond.
// Notes: All slow timers in the sequencer count these pulses.
`timescale 1ns/10ps
`default_nettype none
module dcls_tick_gen #(
  parameter int CYCLES = 200000
) (
  input wire logic sys_clk_i,  // System clock.
  input wire logic resetn_i,   // Asynchronous reset, active low.
  output logic tick_o          // One-cycle pulse each period.
);

  logic [31:0] count;

  // Count system clocks and pulse at the end of each period.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= 32'h0;
      tick_o <= 1'b0;
    end else if (count == 32'(CYCLES - 1)) begin
      count <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: rtl/dcls_dtr_filter.sv
// Purpose: Synchronises the DTR pin and debounces it on millisecond ticks.
// Assumes: dtr_i is asynchronous to sys_clk_i.
// Notes: A change counts only after the second and third stages agree and stays stable.
`timescale 1ns/10ps
`default_nettype none
module dcls_dtr_filter #(
  parameter int TICKS = 2
) (
  input wire logic sys_clk_i,  // System clock.
  input wire logic resetn_i,   // Asynchronous reset, active low.
  input wire logic tick_i,     // Millisecond enable.
  input wire logic dtr_i,      // Raw DTR pin, high is ON.
  output logic dtr_o           // Filtered DTR level.
);

  logic s1, s2, s3;
  logic [7:0] stable;

  // Three-stage synchroniser; only stages two and three are compared.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= dtr_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a new level only after it has held for TICKS milliseconds.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stable <= 8'h0;
      dtr_o <= 1'b0;
    end else if (s2 != s3 || s3 == dtr_o) begin
      stable <= 8'h0;
    end else if (tick_i) begin
      if (stable == 8'(TICKS - 1)) begin
        dtr_o <= s3;
        stable <= 8'h0;
      end else begin
        stable <= stable + 8'h1;
      end
    end
  end

endmodule
`default_nettype wire

// file: sim/dcls_checker.sv
// Purpose: Port-level assertions for the control-lead sequencer.
// Assumes: The mode only changes while reset is held.
// Notes: Bound to dcls_sequencer below the module.
`timescale 1ns/10ps
`default_nettype none
module dcls_checker #(
  parameter int MS_CYCLES = 200000,
  parameter int DROP_MS = 200
) (
  input wire logic sys_clk_i, // Clock.
  input wire logic resetn_i, // Reset, low.
  input wire logic [3:0] mode_i, // Mode.
  input wire logic [2:0] baud_switch_i, // Switches.
  input wire logic call_released_i, // Far release.
  input wire logic break_release_i, // Break release.
  input wire logic cts_o, // CTS.
  input wire logic dsr_o, // DSR.
  input wire logic dcd_o, // DCD.
  input wire logic ri_o, // RI.
  input wire logic answer_o, // Answer strobe.
  input wire logic make_set_busy_o, // Busy level.
  input wire logic [2:0] hotline_baud_o, // Baud code.
  input wire logic prompts_en_o, // Prompts.
  input wire logic echo_en_o, // Echo.
  input wire logic cmd_accept_o, // Commands.
  input wire logic [2:0] state_o // State.
);
  localparam int DROP_LO = (DROP_MS - 1) * MS_CYCLES;
  localparam int DROP_HI = (DROP_MS + 1) * MS_CYCLES;
  logic host;
  logic [31:0] drop_cnt;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // Host modes are 8 to 11.
  assign host = (mode_i[3:2] == 2'b10);
  // Counts the cycles spent in the drop state.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drop_cnt <= 32'h0;
    end else if (state_o == 3'h6) begin
      drop_cnt <= drop_cnt + 32'h1;
    end else begin
      drop_cnt <= 32'h0;
    end
  end
  property p_idle_off; host && state_o == 3'h0 && $past(state_o) == 3'h0 |-> !(cts_o || dsr_o || dcd_o); endproperty
  a_idle_off: assert property (p_idle_off) else $error("lead on in host idle");
  property p_host_quiet; host |-> !prompts_en_o && !echo_en_o; endproperty
  a_host_quiet: assert property (p_host_quiet) else $error("prompt or echo in host mode");
  property p_term_talk; mode_i[3:2] == 2'b11 |-> prompts_en_o && echo_en_o; endproperty
  a_term_talk: assert property (p_term_talk) else $error("prompt or echo off in terminal mode");
  property p_conn_on; host && state_o == 3'h3 && $past(state_o) == 3'h3 |-> cts_o && dsr_o && dcd_o; endproperty
  a_conn_on: assert property (p_conn_on) else $error("lead off while connected");
  property p_answer; answer_o |-> state_o == 3'h2; endproperty
  a_answer: assert property (p_answer) else $error("answer strobe outside answer state");
  property p_ri_ring; ri_o |-> state_o == 3'h1 || $past(state_o) == 3'h1; endproperty
  a_ri_ring: assert property (p_ri_ring) else $error("ring outside ringing");
  property p_baud; mode_i == 4'hB |-> hotline_baud_o == baud_switch_i; endproperty
  a_baud: assert property (p_baud) else $error("hotline baud not from switches");
  property p_forced_hold;
    mode_i == 4'hA && state_o == 3'h3 && !call_released_i && !break_release_i |=> state_o == 3'h3;
  endproperty
  a_forced_hold: assert property (p_forced_hold) else $error("forced mode left connection");
  property p_forced_idle; mode_i == 4'hA && $past(mode_i) == 4'hA |-> !make_set_busy_o; endproperty
  a_forced_idle: assert property (p_forced_idle) else $error("busy in forced mode");
  property p_cmd14; mode_i == 4'hE |-> cmd_accept_o; endproperty
  a_cmd14: assert property (p_cmd14) else $error("commands refused in mode 14");
  property p_drop_off; state_o == 3'h6 && $past(state_o) == 3'h6 |-> !dsr_o && !dcd_o; endproperty
  a_drop_off: assert property (p_drop_off) else $error("lead on during drop");
  property p_drop_len; state_o != 3'h6 && $past(state_o) == 3'h6 |-> drop_cnt >= DROP_LO && drop_cnt <= DROP_HI;
  endproperty
  a_drop_len: assert property (p_drop_len) else $error("drop length wrong");
  property p_m12_on;
    mode_i == 4'hC && state_o != 3'h6 && $past(state_o) != 3'h6 && $past(resetn_i) |-> cts_o && dsr_o && dcd_o;
  endproperty
  a_m12_on: assert property (p_m12_on) else $error("mode 12 lead off outside drop");
endmodule
bind dcls_sequencer dcls_checker #(.MS_CYCLES(MS_CYCLES), .DROP_MS(DROP_MS)) u_dcls_checker (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .mode_i(mode_i), .baud_switch_i(baud_switch_i),
  .call_released_i(call_released_i), .break_release_i(break_release_i), .cts_o(cts_o), .dsr_o(dsr_o),
  .dcd_o(dcd_o), .ri_o(ri_o), .answer_o(answer_o), .make_set_busy_o(make_set_busy_o),
  .hotline_baud_o(hotline_baud_o), .prompts_en_o(prompts_en_o), .echo_en_o(echo_en_o),
  .cmd_accept_o(cmd_accept_o), .state_o(state_o));
`default_nettype wire

// file: sim/dcls_dte_model.sv
// Purpose: Host or terminal on the far side, driving DTR.
// Assumes: The bench sets the wanted DTR level and auto-answer.
// Notes: Answers a ring by raising DTR until auto-answer is withdrawn.
`timescale 1ns/10ps
`default_nettype none
module dcls_dte_model (
  input wire logic sys_clk_i, // Clock.
  input wire logic resetn_i, // Reset, low.
  input wire logic ri_i, // Ring from the device.
  input wire logic auto_answer_i, // Answer rings.
  input wire logic dtr_req_i, // Wanted DTR level.
  output logic dtr_o // DTR to the device.
);
  logic answered;
  // Raises DTR on a ring and drops it when told, to answer and release.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      answered <= 1'b0;
    end else begin
      answered <= auto_answer_i && (answered || ri_i);
    end
  end
  assign dtr_o = dtr_req_i | answered;
endmodule
`default_nettype wire

// file: sim/dce_control_lead_sequencer_bench.sv
// Purpose: Self-checking bench for the control-lead sequencer.
// Assumes: One millisecond is shortened to ten clocks.
// Notes: Each scenario starts from a fresh reset with its mode set.
`include "dcls_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module dce_control_lead_sequencer_bench;
  localparam int MS = 10;
  localparam int RING_ON = 4;
  localparam int RING_OFF = 6;
  localparam int REL = 5;
  localparam int BUSY = 12;
  localparam int RETRY = 20;
  localparam int DROP = 3;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] mode = 4'h8;
  logic opt = 1'b0;
  logic [2:0] baud = 3'h0;
  logic dtr_req = 1'b0;
  logic auto_ans = 1'b0;
  logic [8:0] ev = 9'h000;
  logic [7:0] rx_char = 8'h00;
  wire logic dtr;
  wire logic cts, dsr, dcd, ri, ans, orig, hot, ragain, rel, busy, prompts, echo, accept;
  wire logic [2:0] hbaud;
  wire logic [2:0] state;
  // Strobes gathered into one vector so the counter can index them.
  wire logic [4:0] strobe = {rel, ragain, hot, orig, ans};
  int err_total = 0;
  int n_checks = 0;
  int cnt [5] = '{0, 0, 0, 0, 0};
  always #2.5 sys_clk = ~sys_clk;
  dcls_sequencer #(.MS_CYCLES(MS), .RING_ON_MS(RING_ON), .RING_OFF_MS(RING_OFF), .RELEASE_MS(REL),
    .BUSY_MS(BUSY), .RETRY_MS(RETRY), .DROP_MS(DROP)) u_dcls_sequencer (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .mode_i(mode), .busy_on_line_drop_option_i(opt),
    .baud_switch_i(baud), .dtr_i(dtr), .call_incoming_i(ev[0]), .protocol_ok_i(ev[1]), .far_answer_i(ev[2]),
    .far_busy_i(ev[3]), .far_free_i(ev[4]), .call_released_i(ev[5]), .break_release_i(ev[6]),
    .dial_cmd_i(ev[7]), .rx_char_valid_i(ev[8]), .rx_char_i(rx_char), .cts_o(cts), .dsr_o(dsr), .dcd_o(dcd),
    .ri_o(ri), .answer_o(ans), .originate_o(orig), .hotline_o(hot), .ring_again_o(ragain), .release_o(rel),
    .make_set_busy_o(busy), .hotline_baud_o(hbaud), .prompts_en_o(prompts), .echo_en_o(echo),
    .cmd_accept_o(accept), .state_o(state));
  dcls_dte_model u_dcls_dte_model (.sys_clk_i(sys_clk), .resetn_i(resetn), .ri_i(ri),
    .auto_answer_i(auto_ans), .dtr_req_i(dtr_req), .dtr_o(dtr));
  // Counts every strobe: answer, originate, hotline, ring-again, release.
  always @(posedge sys_clk) begin
    for (int i = 0; i < 5; i++) begin
      if (strobe[i] === 1'b1) cnt[i]++;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Resets for six cycles with a new mode and DTR level, then lets DTR settle.
  task automatic restart(input logic [3:0] m, input logic d);
    @(negedge sys_clk);
    resetn = 1'b0;
    mode = m;
    dtr_req = d;
    auto_ans = 1'b0;
    opt = 1'b0;
    repeat (6) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (40) @(negedge sys_clk);
  endtask
  task automatic pulse(input int k);
    @(negedge sys_clk);
    ev[k] = 1'b1;
    @(negedge sys_clk);
    ev[k] = 1'b0;
  endtask
  task automatic wait_state(input logic [2:0] s, input int lim);
    for (int i = 0; i < lim && state !== s; i++) @(negedge sys_clk);
    check(state, s);
  endtask
  task automatic hold_len(input logic [2:0] s, output int n);
    for (n = 0; n < 1000 && state === s; n++) @(negedge sys_clk);
  endtask
  task automatic ri_len(input logic lv, output int n);
    for (n = 0; n < 1000 && ri === lv; n++) @(negedge sys_clk);
  endtask
  task automatic wait_strobe(input int k, input int lim, output int n);
    int c;
    c = cnt[k];
    for (n = 0; n < lim && cnt[k] == c; n++) @(negedge sys_clk);
  endtask
  // Host ring cadence, answer by DTR, release by a long drop, then make-set-busy.
  task automatic t_host_ring();
    int n;
    int c;
    restart(4'h8, 1'b0);
    check({cts, dsr, dcd, prompts, echo}, 5'h00);
    opt = 1'b1;
    pulse(0);
    wait_state(3'h1, 4);
    ri_len(1'b1, n);
    check(n >= (RING_ON - 1) * MS && n <= (RING_ON + 1) * MS, 1'b1);
    ri_len(1'b0, n);
    check(n >= (RING_OFF - 1) * MS && n <= (RING_OFF + 1) * MS, 1'b1);
    c = cnt[0];
    auto_ans = 1'b1;
    wait_state(3'h2, 80);
    @(negedge sys_clk);
    check(cnt[0] - c, 1);
    pulse(1);
    wait_state(3'h3, 3);
    check({cts, dsr, dcd, ri}, 4'hE);
    c = cnt[4];
    auto_ans = 1'b0;
    hold_len(3'h3, n);
    check(n > REL * MS && state === 3'h0 && busy === 1'b0, 1'b1);
    @(negedge sys_clk);
    check(cnt[4] - c, 1);
    repeat (BUSY * MS) @(negedge sys_clk);
    check(busy, 1'b1);
  endtask
  // Answer at once with DTR on, blind dialing, glitch filtering and mode 9 hotline.
  task automatic t_host_misc();
    int n;
    restart(4'h3, 1'b1);
    pulse(0);
    check({state, cts, ri}, 5'h00);
    restart(4'h8, 1'b1);
    pulse(0);
    wait_state(3'h2, 2);
    check(ri, 1'b0);
    restart(4'h8, 1'b1);
    pulse(7);
    wait_state(3'h4, 2);
    @(negedge sys_clk);
    check(cnt[1] > 0, 1'b1);
    pulse(2);
    wait_state(3'h3, 2);
    restart(4'h9, 1'b0);
    dtr_req = 1'b1;
    repeat (3) @(negedge sys_clk);
    dtr_req = 1'b0;
    wait_strobe(2, 60, n);
    check(n, 60);
    dtr_req = 1'b1;
    wait_strobe(2, 60, n);
    check(n < 60 && state === 3'h4, 1'b1);
  endtask
  // Mode 11 leased line: baud, retry spacing, ring-again and redial.
  task automatic t_leased();
    int n;
    baud = 3'h5;
    restart(4'hB, 1'b1);
    check(hbaud, 3'h5);
    wait_state(3'h4, 40);
    wait_strobe(2, 400, n);
    wait_strobe(2, 400, n);
    check(n >= (RETRY - 1) * MS && n <= (RETRY + 1) * MS, 1'b1);
    pulse(3);
    wait_state(3'h5, 2);
    @(negedge sys_clk);
    check(cnt[3] > 0, 1'b1);
    pulse(4);
    wait_state(3'h3, 2);
    pulse(5);
    wait_state(3'h4, 10);
  endtask
  // Forced DTR in mode 10 and mode 14, and mode 12 terminal behaviour.
  task automatic t_forced_term();
    int n;
    restart(4'hA, 1'b0);
    pulse(0);
    wait_state(3'h2, 2);
    pulse(1);
    repeat ((REL + 4) * MS) @(negedge sys_clk);
    check(state, 3'h3);
    pulse(6);
    wait_state(3'h0, 2);
    restart(4'hC, 1'b0);
    check({cts, dsr, dcd, prompts, echo, accept}, 6'h3E);
    pulse(0);
    repeat (20) @(negedge sys_clk);
    check(state, 3'h1);
    restart(4'hC, 1'b1);
    check(accept, 1'b1);
    rx_char = `DCLS_CTRL_Z;
    pulse(8);
    wait_state(3'h6, 2);
    check({cts, dsr, dcd}, 3'h0);
    hold_len(3'h6, n);
    check(n >= (DROP - 1) * MS && n <= (DROP + 1) * MS, 1'b1);
    check({cts, dsr, dcd}, 3'h7);
    restart(4'hE, 1'b0);
    pulse(0);
    wait_state(3'h2, 2);
    pulse(1);
    pulse(5);
    wait_state(3'h6, 2);
    check({dsr, dcd, ri}, 3'h0);
  endtask
  // Whole run is near 1500 clocks; the watchdog allows far more.
  initial begin
    #150000;
    err_total++;
    results();
  end
  initial begin
    t_host_ring();
    t_host_misc();
    t_leased();
    t_forced_term();
    results();
  end
endmodule
`default_nettype wire
